// ---- src/prc_ratio_ctrl.sv ----
// ratio selection, modifiers, range detector and clock output gate
// assumes mode pins, reference input and synthesizer clock are sampled on ref_clk
`timescale 1ns/1ns
`default_nettype none
module prc_ratio_ctrl
  import prc_pkg::*;
#(
  parameter int RELOCK_CYC = PRC_RELOCK_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic [1:0]  mode_sel,
  input  wire logic        third_mode_pin,
  input  wire logic        ref_in,
  input  wire logic        synth_clk,
  input  wire logic        pll_locked,
  output logic      [31:0] effective_ratio,
  output logic             ratio_format_select,
  output logic             relock_req,
  output logic             clk_out,
  output logic             clk_out_oe
);

  // every check in this module runs on the one device clock and sleeps in reset
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // address decode shared by write and read paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
    hit = (a == base);
  endfunction

  // stored ratios and configuration
  logic [31:0] stored_ratio_set_r [4];
  logic [PRC_G_WIDTH-1:0] global_r;
  logic [15:0] modal_r;
  logic [31:0] rdata_r;
  logic [31:0] eff_r;
  logic [1:0]  input_rate_range_r;
  logic [8:0]  rate_cnt_r;
  logic        ref_prev_r;
  logic [1:0]  mode_prev_r;
  logic [15:0] hold_r;
  logic        relock_r;
  logic        clk_out_r;
  logic        oe_r;

  // decoded fields
  wire logic [2:0] pin_two_function_select = global_r[PRC_G_FUNC_LO +: 3];
  wire logic       output_during_unlock = global_r[PRC_G_UNLOCK];
  wire logic [3:0] modal_set = modal_r[mode_sel*PRC_M_STRIDE +: PRC_M_STRIDE];
  wire logic [1:0] manual_modifier_select = modal_set[1:0];
  wire logic [31:0] user_ratio = stored_ratio_set_r[mode_sel];
  wire logic       ref_rise = ref_in & ~ref_prev_r;
  wire logic       mode_chg = (mode_sel != mode_prev_r);
  wire logic       lock_ok = pll_locked & (hold_r == 16'h0000);

  wire logic manual_en = (pin_two_function_select == PRC_FN_MANUAL) & third_mode_pin;
  wire logic auto_en = (pin_two_function_select == PRC_FN_AUTO) ? third_mode_pin
                                                                 : modal_set[PRC_M_AUTO];
  wire logic [2:0] man_shift = manual_en ? {1'b0, manual_modifier_select} + 3'h1 : 3'h0;
  // auto factor as shift; code 11 treated like 10
  wire logic [2:0] auto_shift = !auto_en ? 3'h0 :
                                (input_rate_range_r == PRC_RNG_SLOW) ? 3'h0 :
                                (input_rate_range_r == PRC_RNG_MID)  ? 3'h1 : 3'h2;
  // combined modifiers; stored values never change
  wire logic [31:0] eff_nxt = user_ratio >> (man_shift + auto_shift);
  // tristate only in codes 000 and 010
  wire logic dis_cfg = (pin_two_function_select == PRC_FN_DIS_ALL) |
                       (pin_two_function_select == PRC_FN_DIS_CLK);
  wire logic oe_nxt = ~(dis_cfg & third_mode_pin);
  wire logic clk_out_nxt = synth_clk & (lock_ok | output_during_unlock);
  wire logic [1:0] range_nxt = (rate_cnt_r > PRC_THR_HI) ? PRC_RNG_SLOW :
                               (rate_cnt_r >= PRC_THR_LO) ? PRC_RNG_MID : PRC_RNG_FAST;
  wire logic [7:0] ratio_idx = reg_addr - PRC_ADDR_RATIO0;
  wire logic       ratio_hit = (reg_addr <= PRC_ADDR_RATIO3) & (reg_addr[1:0] == 2'h0);

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ratio
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          stored_ratio_set_r[gi] <= PRC_RATIO_RST;
        end else if (reg_wr && ratio_hit && ratio_idx[3:2] == 2'(gi)) begin
          stored_ratio_set_r[gi] <= reg_wdata;
        end
      end
    end
  endgenerate

  // configuration writes
  // modal sets held side by side
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      global_r <= PRC_GLOBAL_RST;
      modal_r  <= PRC_MODAL_RST;
    end else if (reg_wr) begin
      if (hit(reg_addr, PRC_ADDR_GLOBAL)) global_r <= reg_wdata[PRC_G_WIDTH-1:0];
      if (hit(reg_addr, PRC_ADDR_MODAL)) modal_r <= reg_wdata[15:0];
    end
  end

  // read mux; unmapped addresses read zero
  wire logic [31:0] status_word = {27'h0, auto_en, manual_en, lock_ok, input_rate_range_r};
  wire logic [31:0] rd_mux =
      ratio_hit ? stored_ratio_set_r[ratio_idx[3:2]] :
      hit(reg_addr, PRC_ADDR_GLOBAL) ? {27'h0, global_r} :
      hit(reg_addr, PRC_ADDR_MODAL)  ? {16'h0, modal_r} :
      hit(reg_addr, PRC_ADDR_STATUS) ? status_word :
      hit(reg_addr, PRC_ADDR_EFF)    ? eff_r : 32'h0;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!rst_n) rdata_r <= 32'h0;
    else rdata_r <= reg_rd ? rd_mux : 32'h0;
  end

  // range detector: count internal clocks per reference period, saturating
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ref_prev_r <= 1'b0;
      rate_cnt_r <= 9'h000;
      input_rate_range_r <= PRC_RNG_SLOW;
    end else begin
      ref_prev_r <= ref_in;
      if (ref_rise) begin
        rate_cnt_r <= 9'h001;
        // first edge after reset measures a partial period; next edge corrects it
        input_rate_range_r <= range_nxt;
      end else if (rate_cnt_r != PRC_CNT_MAX) begin
        rate_cnt_r <= rate_cnt_r + 9'h001;
      end
    end
  end

  // mode change drops lock for a hold time
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mode_prev_r <= 2'h0;
      hold_r      <= 16'h0000;
      relock_r    <= 1'b0;
    end else begin
      mode_prev_r <= mode_sel;
      relock_r    <= mode_chg;
      if (mode_chg) hold_r <= 16'(RELOCK_CYC);
      else if (hold_r != 16'h0000) hold_r <= hold_r - 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      eff_r     <= 32'h0;
      clk_out_r <= 1'b0;
      oe_r      <= 1'b0;
    end else begin
      eff_r     <= eff_nxt;
      clk_out_r <= clk_out_nxt;
      oe_r      <= oe_nxt;
    end
  end

  // outputs come straight from flip-flops
  assign reg_rdata = rdata_r;
  assign effective_ratio = eff_r;
  // format bit passed beside the ratio
  assign ratio_format_select = global_r[PRC_G_FORMAT];
  assign relock_req = relock_r;
  assign clk_out = clk_out_r;
  assign clk_out_oe = oe_r;

  // checks on the block's own outputs and internal decode

  property p_select_plain;
    (!manual_en && !auto_en) |=> eff_r == $past(stored_ratio_set_r[mode_sel]);
  endproperty
  a_select_plain: assert property (p_select_plain) else $error("plain ratio wrong");

  property p_manual_shift;
    (manual_en && !auto_en && manual_modifier_select == 2'h3) |=>
      eff_r == ($past(user_ratio) >> 4);
  endproperty
  a_manual_shift: assert property (p_manual_shift) else $error("manual divide wrong");

  property p_manual_pin;
    (pin_two_function_select != PRC_FN_MANUAL) |-> !manual_en;
  endproperty
  a_manual_pin: assert property (p_manual_pin) else $error("manual enabled wrongly");

  property p_auto_pin;
    (pin_two_function_select == PRC_FN_AUTO) |-> auto_en == third_mode_pin;
  endproperty
  a_auto_pin: assert property (p_auto_pin) else $error("auto pin override lost");

  property p_range_slow;
    (ref_rise && rate_cnt_r > PRC_THR_HI) |=> input_rate_range_r == PRC_RNG_SLOW;
  endproperty
  a_range_slow: assert property (p_range_slow) else $error("range code not 00");

  property p_range_fast;
    (ref_rise && rate_cnt_r < PRC_THR_LO) |=> input_rate_range_r == PRC_RNG_FAST;
  endproperty
  a_range_fast: assert property (p_range_fast) else $error("range code not 10");

  property p_unlock_low;
    (!pll_locked && !output_during_unlock) |=> !clk_out_r;
  endproperty
  a_unlock_low: assert property (p_unlock_low) else $error("output not low unlocked");

  property p_disable;
    (pin_two_function_select == PRC_FN_DIS_CLK && third_mode_pin) |=> !clk_out_oe;
  endproperty
  a_disable: assert property (p_disable) else $error("output not disabled");

  property p_relock;
    mode_chg |=> relock_req ##0 !lock_ok [*2];
  endproperty
  a_relock: assert property (p_relock) else $error("mode change kept lock");

  property p_read_once;
    reg_rd && hit(reg_addr, PRC_ADDR_GLOBAL) |=> reg_rdata == {27'h0, $past(global_r)};
  endproperty
  a_read_once: assert property (p_read_once) else $error("register read wrong");

  // smallest manual step halves the ratio
  property p_manual_half;
    (manual_en && !auto_en && manual_modifier_select == 2'h0) |=>
      eff_r == ($past(user_ratio) >> 1);
  endproperty
  a_manual_half: assert property (p_manual_half) else $error("manual halve wrong");

  // range 00 leaves the ratio as it is
  property p_auto_slow;
    (auto_en && !manual_en && input_rate_range_r == PRC_RNG_SLOW) |=>
      eff_r == $past(user_ratio);
  endproperty
  a_auto_slow: assert property (p_auto_slow) else $error("auto unity factor wrong");

  property p_auto_mid;
    (auto_en && !manual_en && input_rate_range_r == PRC_RNG_MID) |=>
      eff_r == ($past(user_ratio) >> 1);
  endproperty
  a_auto_mid: assert property (p_auto_mid) else $error("auto half factor wrong");

  property p_auto_fast;
    (auto_en && !manual_en && input_rate_range_r == PRC_RNG_FAST) |=>
      eff_r == ($past(user_ratio) >> 2);
  endproperty
  a_auto_fast: assert property (p_auto_fast) else $error("auto quarter wrong");

  // both modifiers stack on the same ratio
  property p_both_mods;
    (manual_en && auto_en && input_rate_range_r == PRC_RNG_MID) |=>
      eff_r == ($past(user_ratio) >> (3'($past(manual_modifier_select)) + 3'h2));
  endproperty
  a_both_mods: assert property (p_both_mods) else $error("stacked modifiers wrong");

  // mid band count gives code 01
  property p_range_mid;
    (ref_rise && rate_cnt_r >= PRC_THR_LO && rate_cnt_r <= PRC_THR_HI) |=>
      input_rate_range_r == PRC_RNG_MID;
  endproperty
  a_range_mid: assert property (p_range_mid) else $error("range code not 01");

  property p_locked_copy;
    lock_ok |=> clk_out_r == $past(synth_clk);
  endproperty
  a_locked_copy: assert property (p_locked_copy) else $error("output not a copy");

  // unlock setting lets the copy through
  property p_unlock_runs;
    output_during_unlock |=> clk_out_r == $past(synth_clk);
  endproperty
  a_unlock_runs: assert property (p_unlock_runs) else $error("unlock output blocked");

  // pin low enables the driver again
  property p_pin_enable;
    (dis_cfg && !third_mode_pin) |=> clk_out_oe;
  endproperty
  a_pin_enable: assert property (p_pin_enable) else $error("output not enabled");

  // other pin functions never float the driver
  property p_oe_other;
    !dis_cfg |=> clk_out_oe;
  endproperty
  a_oe_other: assert property (p_oe_other) else $error("driver floated wrongly");

  // modal bit rules unless the pin overrides
  property p_modal_auto;
    (pin_two_function_select != PRC_FN_AUTO) |-> auto_en == modal_set[PRC_M_AUTO];
  endproperty
  a_modal_auto: assert property (p_modal_auto) else $error("modal auto enable lost");

  // code 011 with pin high enables manual
  property p_manual_on;
    (pin_two_function_select == PRC_FN_MANUAL && third_mode_pin) |-> manual_en;
  endproperty
  a_manual_on: assert property (p_manual_on) else $error("manual not enabled");

  c_manual: cover property (manual_en && auto_en ##1 eff_r != user_ratio);
  c_relock: cover property (mode_chg ##[1:40] lock_ok);
  c_mid: cover property (input_rate_range_r == PRC_RNG_MID && auto_en);
  c_tristate: cover property (!clk_out_oe ##1 clk_out_oe);

endmodule // prc_ratio_ctrl
`default_nettype wire

// ---- src/prc_pkg.sv ----
// package for the ratio control and clock output gate
// assumes one 100 MHz internal clock and a plain strobe register port
package prc_pkg;
  // register byte addresses
  localparam logic [7:0] PRC_ADDR_RATIO0  = 8'h00;
  localparam logic [7:0] PRC_ADDR_RATIO3  = 8'h0C;
  localparam logic [7:0] PRC_ADDR_GLOBAL  = 8'h10;
  localparam logic [7:0] PRC_ADDR_MODAL   = 8'h14;
  localparam logic [7:0] PRC_ADDR_STATUS  = 8'h18;
  localparam logic [7:0] PRC_ADDR_EFF     = 8'h1C;
  // global field positions
  localparam int PRC_G_FORMAT = 0;
  localparam int PRC_G_FUNC_LO = 1;
  localparam int PRC_G_UNLOCK = 4;
  localparam int PRC_G_WIDTH = 5;
  // modal field layout, four bits per set
  localparam int PRC_M_STRIDE = 4;
  localparam int PRC_M_AUTO = 2;
  // reset values
  localparam logic [31:0] PRC_RATIO_RST  = 32'h0000_0000;
  localparam logic [4:0]  PRC_GLOBAL_RST = 5'h00;
  localparam logic [15:0] PRC_MODAL_RST  = 16'h0000;
  // pin function select codes
  localparam logic [2:0] PRC_FN_DIS_ALL  = 3'h0;
  localparam logic [2:0] PRC_FN_DIS_CLK  = 3'h2;
  localparam logic [2:0] PRC_FN_MANUAL   = 3'h3;
  localparam logic [2:0] PRC_FN_AUTO     = 3'h5;
  // range codes and thresholds in internal clock cycles per reference period
  localparam logic [1:0] PRC_RNG_SLOW = 2'h0;
  localparam logic [1:0] PRC_RNG_MID  = 2'h1;
  localparam logic [1:0] PRC_RNG_FAST = 2'h2;
  localparam logic [8:0] PRC_THR_HI = 9'h0E0;
  localparam logic [8:0] PRC_THR_LO = 9'h060;
  localparam logic [8:0] PRC_CNT_MAX = 9'h1FF;
  // relock hold after a mode change
  localparam int PRC_CLK_MHZ = 100;
  localparam int PRC_RELOCK_NS = 200;
  localparam int PRC_RELOCK_CYC = (PRC_RELOCK_NS * PRC_CLK_MHZ + 999) / 1000;
endpackage

// ---- tb/prc_far_side.sv ----
// far-side model: reference clock input and synthesizer output
// assumes the bench holds period steady long enough to be measured
`timescale 1ns/1ns
`default_nettype none
module prc_far_side (
  input  wire logic       ref_clk,
  input  wire logic [9:0] period,
  output var  logic       ref_in,
  output var  logic       synth_clk
);
  logic [9:0] cnt_r;
  initial begin
    cnt_r = 10'h000;
    ref_in = 1'b0;
    synth_clk = 1'b0;
  end
  // one-cycle reference pulse every period cycles; synthesizer toggles each cycle
  // so a gated output shows exactly half its samples high
  always @(posedge ref_clk) begin
    cnt_r <= (cnt_r >= period - 10'h001) ? 10'h000 : cnt_r + 10'h001;
    ref_in <= (cnt_r == 10'h000);
    synth_clk <= ~synth_clk;
  end
endmodule // prc_far_side
`default_nettype wire

// ---- tb/pll_ratio_config_and_output_test.sv ----
// self-checking bench for the ratio control and clock output gate
// assumes prc_pkg is compiled first; far side comes from prc_far_side
`timescale 1ns/1ns
`default_nettype none
module pll_ratio_config_and_output_test;
  import prc_pkg::*;
  localparam int RC = 8;
  logic        ref_clk, rst_n, reg_wr, reg_rd, third_mode_pin, pll_locked;
  logic        ratio_format_select, relock_req, clk_out, clk_out_oe, ref_in, synth_clk;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, effective_ratio, d;
  logic [1:0]  mode_sel, rng;
  logic [9:0]  period;
  logic [15:0] modal;
  logic [31:0] rat [4];
  logic [4:0]  cfg [5] = '{5'b00010, 5'b01010, 5'b01001, 5'b01111, 5'b00111};
  int          num_errors, compares, n;

  prc_ratio_ctrl #(.RELOCK_CYC(RC)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mode_sel(mode_sel), .third_mode_pin(third_mode_pin),
    .ref_in(ref_in), .synth_clk(synth_clk), .pll_locked(pll_locked),
    .effective_ratio(effective_ratio), .ratio_format_select(ratio_format_select),
    .relock_req(relock_req), .clk_out(clk_out), .clk_out_oe(clk_out_oe));
  prc_far_side far (.ref_clk(ref_clk), .period(period), .ref_in(ref_in),
    .synth_clk(synth_clk));

  // comparison, register bus and verdict helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic cnt_hi(input int k, output int h);
    h = 0;
    repeat (k) begin
      @(posedge ref_clk);
      #1 h += (clk_out === 1'b1);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // expected ratio: manual shift by select plus one, then shift by range
  function automatic logic [31:0] eff(logic [31:0] r, logic m, logic [1:0] s, logic a,
                                      logic [1:0] g);
    logic [31:0] e;
    e = m ? r >> (3'(s) + 3'h1) : r;
    return a ? e >> ((g == 2'h0) ? 0 : (g == 2'h1) ? 1 : 2) : e;
  endfunction
  // walk all four modes under one pin function and a random modal set
  task automatic modes(input logic [2:0] fn, input logic pin);
    logic [1:0] old;
    int p;
    logic [31:0] e;
    modal = 16'($urandom);
    wr(PRC_ADDR_MODAL, {16'h0000, modal});
    wr(PRC_ADDR_GLOBAL, {27'h0, 1'b1, fn, 1'($urandom)});
    third_mode_pin <= pin;
    for (int m = 3; m < 7; m++) begin
      @(posedge ref_clk);
      old = mode_sel;
      mode_sel <= 2'(m);
      p = 0;
      repeat (RC + 4) begin
        @(posedge ref_clk);
        #1 p += (relock_req === 1'b1);
      end
      chk(32'(p), {31'h0, 2'(m) != old}, "relock pulses");
      e = eff(rat[m % 4], fn == 3'h3 && pin, modal[4 * (m % 4) +: 2],
              (fn == 3'h5) ? pin : modal[4 * (m % 4) + 2], rng);
      chk(effective_ratio, e, "eff ratio");
    end
  endtask

  // free-running device clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // watchdog: whole run needs well under this span
  initial begin
    #500000;
    num_errors++;
    stop_test;
  end
  // main sequence
  initial begin
    {rst_n, reg_wr, reg_rd, third_mode_pin, pll_locked} = 5'h00;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    mode_sel = 2'h0;
    period = 10'h12C;
    rng = 2'h0;
    num_errors = 0;
    compares = 0;
    void'($urandom(67884));
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(PRC_ADDR_GLOBAL, d);
    chk(d, 32'h0, "global reset");
    rd(PRC_ADDR_MODAL, d);
    chk(d, 32'h0, "modal reset");
    rd(8'h02, d);
    chk(d, 32'h0, "misaligned read");
    wr(PRC_ADDR_EFF, 32'hFFFF_FFFF);
    rd(PRC_ADDR_EFF, d);
    chk(d, 32'h0, "read-only ratio");
    // top bit set, low byte clear
    // keeps 20.12 ratios above 4096 and lets no shift truncate
    for (int i = 0; i < 4; i++) begin
      rat[i] = ($urandom | 32'h8000_0000) & 32'hFFFF_FF00;
      wr(PRC_ADDR_RATIO0 + 8'(4 * i), rat[i]);
    end
    for (int i = 0; i < 4; i++) begin
      rd(PRC_ADDR_RATIO0 + 8'(4 * i), d);
      chk(d, rat[i], "ratio readback");
    end
    wr(PRC_ADDR_GLOBAL, 32'h1);
    rd(PRC_ADDR_GLOBAL, d);
    chk({31'h0, ratio_format_select}, 32'h1, "format 20.12");
    wr(PRC_ADDR_GLOBAL, 32'h0);
    rd(PRC_ADDR_GLOBAL, d);
    chk({31'h0, ratio_format_select}, 32'h0, "format 12.20");
    @(posedge ref_clk);
    pll_locked <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      @(posedge ref_clk);
      period <= (k == 0) ? 10'h12C : (k == 1) ? 10'h096 : 10'h032;
      rng = 2'(k);
      repeat (700) @(posedge ref_clk);
      rd(PRC_ADDR_STATUS, d);
      chk({30'h0, d[1:0]}, {30'h0, rng}, "range code");
      modes(3'h4, 1'b0);
      modes(3'h3, 1'b1);
      modes(3'h3, 1'b0);
      modes(3'h5, 1'b1);
      modes(3'h5, 1'b0);
    end
    // driver enable per pin function and pin level
    for (int j = 0; j < 5; j++) begin
      wr(PRC_ADDR_GLOBAL, {27'h0, 1'b0, cfg[j][4:2], 1'b0});
      third_mode_pin <= cfg[j][1];
      repeat (3) @(posedge ref_clk);
      #1 chk({31'h0, clk_out_oe}, {31'h0, cfg[j][0]}, "driver enable");
    end
    cnt_hi(8, n);
    chk(32'(n), 32'h4, "locked output runs");
    @(posedge ref_clk);
    pll_locked <= 1'b0;
    repeat (3) @(posedge ref_clk);
    cnt_hi(8, n);
    chk(32'(n), 32'h0, "unlocked output low");
    wr(PRC_ADDR_GLOBAL, 32'h10);
    repeat (3) @(posedge ref_clk);
    cnt_hi(8, n);
    chk(32'(n), 32'h4, "unlocked output runs");
    wr(PRC_ADDR_GLOBAL, 32'h0);
    pll_locked <= 1'b1;
    repeat (RC + 4) @(posedge ref_clk);
    mode_sel <= mode_sel + 2'h1;
    repeat (2) @(posedge ref_clk);
    cnt_hi(4, n);
    chk(32'(n), 32'h0, "output held during relock");
    repeat (RC + 4) @(posedge ref_clk);
    rd(PRC_ADDR_STATUS, d);
    chk({31'h0, d[2]}, 32'h1, "lock regained");
    stop_test;
  end
endmodule // pll_ratio_config_and_output_test
`default_nettype wire
